// file: verilog/apd_pkg.sv
package apd_pkg;

    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_CMD      = 8'h04;
    localparam logic [7:0] ADR_ACCEL    = 8'h08;
    localparam logic [7:0] ADR_INMODE   = 8'h0C;
    localparam logic [7:0] ADR_INITSPD  = 8'h10;
    localparam logic [7:0] ADR_DRVSPD   = 8'h14;
    localparam logic [7:0] ADR_RATE     = 8'h18;
    localparam logic [7:0] ADR_PULSES   = 8'h1C;
    localparam logic [7:0] ADR_DECPT    = 8'h20;
    localparam logic [7:0] ADR_OFFSET   = 8'h24;
    localparam logic [7:0] ADR_STATUS   = 8'h28;
    localparam logic [7:0] ADR_OUTCNT   = 8'h2C;
    localparam logic [7:0] ADR_SPEED    = 8'h30;

    // ************************************************************
    // Commands
    // ************************************************************
    localparam logic [7:0] CMD_FIX_POS  = 8'h20;
    localparam logic [7:0] CMD_FIX_NEG  = 8'h21;
    localparam logic [7:0] CMD_CON_POS  = 8'h22;
    localparam logic [7:0] CMD_CON_NEG  = 8'h23;
    localparam logic [7:0] CMD_DEC_STOP = 8'h26;
    localparam logic [7:0] CMD_SUD_STOP = 8'h27;
    localparam logic [7:0] CMD_DECPT    = 8'h07;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int BIT_MANUAL_DECEL = 0;
    localparam int BIT_NONSYM_DECEL = 1;
    localparam int BIT_SCURVE       = 2;
    localparam logic [31:0] OFFSET_RST  = 32'h0000_0008;
    localparam logic [31:0] INITSPD_RST = 32'h0000_0001;
    localparam logic [31:0] ZERO32      = 32'h0000_0000;
    // Speed accumulator overflow per output pulse
    localparam logic [31:0] PHASE_FULL  = 32'h0010_0000;

    typedef enum logic [1:0] {
        APD_IDLE  = 2'b00,
        APD_ACCEL = 2'b01,
        APD_CONST = 2'b11,
        APD_DECEL = 2'b10
    } apd_state_t;

    typedef struct packed {
        logic [3:0] enable;
        logic [3:0] active_high;
        logic [3:0] sudden;
    } apd_inmode_t;

endpackage : apd_pkg

// file: verilog/apd_axis.sv
// What this block does
// - Equal-rate fixed drive decelerates when remaining pulses below accel pulses; stops at count.
// - New pulse count accepted while driving; larger count extends the move.
// - New count below pulses already output stops pulse output at once.
// - Manual decel select set makes the decel point register the deceleration point; command 07h is not decoded.
// - Drive speed accepted while running in linear or constant fixed driving.
// - Accel pulses compared with remaining, deceleration advanced by signed offset.
// - Acceleration counter offset resets to eight.
// - Continuous drive runs until stop command or enabled external stop input.
// - Drive speed rewritable anytime in continuous drive; rate follows.
// - Decelerating stop and sudden stop commands exist.
// - Four external stop inputs with enable, level and mode each.
// - Z-phase, home, near-home enable and level set in input mode register.
// - Accel continuous drive decelerates to stop on active enabled inputs 3..0 not set to sudden mode.
// - Constant-speed continuous drive stops suddenly on home input.
// - Drive speed not above initial speed means constant-speed drive; fixed drive changes to initial speed at the decel point.
// - Fixed or continuous drive starts in either direction on command.
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module apd_axis #(
    parameter int SPD_W = 32
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // External stop pins
    input  wire logic [3:0]  i_ext_stop,
    // Pulse and busy outputs
    output logic             o_pulse_pos,
    output logic             o_pulse_neg,
    output logic             o_busy
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0]           ctrl_q;
    logic [31:0]           accel_q;
    logic [31:0]           initspd_q;
    logic [31:0]           drvspd_q;
    logic [31:0]           rate_q;
    logic [31:0]           pulses_q;
    logic [31:0]           decpt_q;
    logic [31:0]           offset_q;
    apd_pkg::apd_inmode_t  inmode_q;
    logic [31:0]           inmode_wr;
    logic [31:0]           outcnt_q;
    logic [31:0]           acccnt_q;
    logic [31:0]           speed_q;
    logic [31:0]           phase_q;
    logic [31:0]           status;
    apd_pkg::apd_state_t   state_q;
    logic                  fixed_q;
    logic                  dir_q;
    logic                  ack_q;
    logic                  pulse_q;
    logic                  stopping_q;
    logic [3:0]            stop_m_q;
    logic [3:0]            stop_s_q;
    logic                  wr;
    logic [31:0]           wmask;
    logic [31:0]           remain;
    logic [31:0]           acc_off;
    logic [3:0]            stop_act;
    logic                  cmd_wr;
    logic                  stop_dec;
    logic                  stop_sud;
    logic                  pulse_tick;
    logic                  reach_dec;
    logic                  done;
    logic [7:0]            cmd;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        wmerge = (old & ~m) | (nw & m);
    endfunction : wmerge

    // ************************************************************
    // Bus access
    // ************************************************************
    assign wr     = i_wb_cyc && i_wb_stb && i_wb_we && !ack_q;
    assign wmask  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    assign cmd_wr = wr && i_wb_adr == apd_pkg::ADR_CMD && i_wb_sel[0];
    assign cmd    = i_wb_dat[7:0];
    assign inmode_wr = wmerge(32'(inmode_q), i_wb_dat, wmask);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
        end
    end
    assign o_wb_ack = ack_q;

    // ************************************************************
    // Register write
    // ************************************************************

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_q    <= apd_pkg::ZERO32;
            accel_q   <= apd_pkg::ZERO32;
            inmode_q  <= '0;
            initspd_q <= apd_pkg::INITSPD_RST;
            drvspd_q  <= apd_pkg::ZERO32;
            rate_q    <= apd_pkg::ZERO32;
            pulses_q  <= apd_pkg::ZERO32;
            decpt_q   <= apd_pkg::ZERO32;
            offset_q  <= apd_pkg::OFFSET_RST;
        end else if (wr) begin
            case (i_wb_adr)
                apd_pkg::ADR_CTRL:    ctrl_q    <= wmerge(ctrl_q, i_wb_dat, wmask);
                apd_pkg::ADR_ACCEL:   accel_q   <= wmerge(accel_q, i_wb_dat, wmask);
                apd_pkg::ADR_INMODE:  inmode_q  <= apd_pkg::apd_inmode_t'(inmode_wr[11:0]);
                apd_pkg::ADR_INITSPD: initspd_q <= wmerge(initspd_q, i_wb_dat, wmask);
                apd_pkg::ADR_DRVSPD:  drvspd_q  <= wmerge(drvspd_q, i_wb_dat, wmask);
                apd_pkg::ADR_RATE:    rate_q    <= wmerge(rate_q, i_wb_dat, wmask);
                apd_pkg::ADR_PULSES:  pulses_q  <= wmerge(pulses_q, i_wb_dat, wmask);
                apd_pkg::ADR_DECPT:   decpt_q   <= wmerge(decpt_q, i_wb_dat, wmask);
                apd_pkg::ADR_OFFSET:  offset_q  <= wmerge(offset_q, i_wb_dat, wmask);
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wb_dat <= apd_pkg::ZERO32;
        end else begin
            case (i_wb_adr)
                apd_pkg::ADR_CTRL:    o_wb_dat <= ctrl_q;
                apd_pkg::ADR_ACCEL:   o_wb_dat <= accel_q;
                apd_pkg::ADR_INMODE:  o_wb_dat <= 32'(inmode_q);
                apd_pkg::ADR_INITSPD: o_wb_dat <= initspd_q;
                apd_pkg::ADR_DRVSPD:  o_wb_dat <= drvspd_q;
                apd_pkg::ADR_RATE:    o_wb_dat <= rate_q;
                apd_pkg::ADR_PULSES:  o_wb_dat <= pulses_q;
                apd_pkg::ADR_DECPT:   o_wb_dat <= decpt_q;
                apd_pkg::ADR_OFFSET:  o_wb_dat <= offset_q;
                apd_pkg::ADR_STATUS:  o_wb_dat <= status;
                apd_pkg::ADR_OUTCNT:  o_wb_dat <= outcnt_q;
                apd_pkg::ADR_SPEED:   o_wb_dat <= speed_q;
                default:              o_wb_dat <= apd_pkg::ZERO32;
            endcase
        end
    end

    // ************************************************************
    // Status word
    // ************************************************************
    assign status = {26'h0,
                     |stop_s_q[1:0],
                     fixed_q,
                     dir_q,
                     state_q,
                     o_busy};

    // ************************************************************
    // External stop synchronisers
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stop_m_q <= 4'h0;
            stop_s_q <= 4'h0;
        end else begin
            stop_m_q <= i_ext_stop;
            stop_s_q <= stop_m_q;
        end
    end

    // ************************************************************
    // Per-pin stop qualification
    // ************************************************************
    for (genvar k = 0; k < 4; k++) begin : g_stop_act
        assign stop_act[k] = inmode_q.enable[k] && (stop_s_q[k] == inmode_q.active_high[k]);
    end

    // ************************************************************
    // Stop and deceleration decisions
    // ************************************************************
    assign remain   = pulses_q - outcnt_q;
    assign acc_off  = acccnt_q + offset_q;
    // Sudden: command, sudden-mode pins, home pin in constant-speed continuous drive
    assign stop_sud = (cmd_wr && cmd == apd_pkg::CMD_SUD_STOP)
                    || |(stop_act & inmode_q.sudden)
                    || (stop_act[1] && !fixed_q && state_q == apd_pkg::APD_CONST
                        && drvspd_q <= initspd_q);
    assign stop_dec = (cmd_wr && cmd == apd_pkg::CMD_DEC_STOP)
                    || |(stop_act & ~inmode_q.sudden);
    // Automatic or manual decel point
    assign reach_dec = fixed_q && (accel_q[apd_pkg::BIT_MANUAL_DECEL]
                     ? (remain <= decpt_q)
                     : ($signed(remain) <= $signed(acc_off)));
    assign done     = fixed_q && (outcnt_q >= pulses_q);

    // ************************************************************
    // Decelerating stop latch
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst || state_q == apd_pkg::APD_IDLE) begin
            stopping_q <= 1'b0;
        end else if (stop_dec) begin
            stopping_q <= 1'b1;
        end
    end

    // ************************************************************
    // Pulse rate generator
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst || state_q == apd_pkg::APD_IDLE) begin
            phase_q <= apd_pkg::ZERO32;
            pulse_q <= 1'b0;
        end else if (phase_q + speed_q >= apd_pkg::PHASE_FULL) begin
            phase_q <= phase_q + speed_q - apd_pkg::PHASE_FULL;
            pulse_q <= 1'b1;
        end else begin
            phase_q <= phase_q + speed_q;
            pulse_q <= 1'b0;
        end
    end
    assign pulse_tick = pulse_q && state_q != apd_pkg::APD_IDLE && !done;

    // ************************************************************
    // Pulse and busy outputs
    // ************************************************************
    assign o_busy      = state_q != apd_pkg::APD_IDLE;
    assign o_pulse_pos = pulse_tick && !dir_q;
    assign o_pulse_neg = pulse_tick && dir_q;

    // ************************************************************
    // Drive sequencer
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q    <= apd_pkg::APD_IDLE;
            fixed_q    <= 1'b0;
            dir_q      <= 1'b0;
            outcnt_q   <= apd_pkg::ZERO32;
            acccnt_q   <= apd_pkg::ZERO32;
            speed_q    <= apd_pkg::ZERO32;
        end else begin
            case (state_q)
                apd_pkg::APD_IDLE: begin
                    if (cmd_wr && cmd[7:2] == apd_pkg::CMD_FIX_POS[7:2]) begin
                        fixed_q    <= !cmd[1];
                        dir_q      <= cmd[0];
                        outcnt_q   <= apd_pkg::ZERO32;
                        acccnt_q   <= apd_pkg::ZERO32;
                        speed_q    <= (drvspd_q <= initspd_q) ? drvspd_q : initspd_q;
                        state_q    <= (drvspd_q <= initspd_q) ? apd_pkg::APD_CONST : apd_pkg::APD_ACCEL;
                    end
                end
                default: begin
                    if (pulse_tick) begin
                        outcnt_q <= outcnt_q + 32'h1;
                        if (state_q == apd_pkg::APD_ACCEL) begin
                            acccnt_q <= acccnt_q + 32'h1;
                        end
                    end
                    if (stop_sud || done) begin
                        state_q <= apd_pkg::APD_IDLE;
                    end else if (state_q == apd_pkg::APD_DECEL) begin
                        // Ramp down, halt at initial speed unless fixed count pending
                        if (speed_q <= initspd_q + rate_q) begin
                            speed_q <= initspd_q;
                            if (!fixed_q || stop_dec || stopping_q) begin
                                state_q <= apd_pkg::APD_IDLE;
                            end
                        end else begin
                            speed_q <= speed_q - rate_q;
                        end
                        if (fixed_q && !reach_dec && !stop_dec && !stopping_q && drvspd_q > initspd_q) begin
                            state_q <= apd_pkg::APD_ACCEL;
                        end
                    end else if (stop_dec || reach_dec) begin
                        state_q <= (drvspd_q <= initspd_q && !fixed_q) ? apd_pkg::APD_IDLE : apd_pkg::APD_DECEL;
                    end else if (state_q == apd_pkg::APD_ACCEL) begin
                        if (speed_q + rate_q >= drvspd_q) begin
                            speed_q <= drvspd_q;
                            state_q <= apd_pkg::APD_CONST;
                        end else begin
                            speed_q <= speed_q + rate_q;
                        end
                    end else begin
                        speed_q <= drvspd_q;
                    end
                end
            endcase
        end
    end

endmodule : apd_axis

// file: verif/apd_axis_chk.sv
`timescale 1ns/1ps
module apd_axis_chk (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // Bus
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    // Pins
    input wire logic [3:0]  i_ext_stop,
    input wire logic        o_pulse_pos,
    input wire logic        o_pulse_neg,
    input wire logic        o_busy
);
    // ****************************************
    // Command decode and direction
    // ****************************************
    logic req;
    logic cmd;
    logic start;
    logic dir_q;
    assign req   = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign cmd   = req && i_wb_we && i_wb_sel[0] && i_wb_adr == apd_pkg::ADR_CMD;
    assign start = cmd && i_wb_dat[7:2] == 6'h08 && !o_busy;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dir_q <= 1'b0;
        end else if (start) begin
            dir_q <= i_wb_dat[0];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_ack_follows: assert property (req |=> o_wb_ack)
        else $error("ack missing after request");
    chk_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held too long");
    chk_ack_cause: assert property (o_wb_ack |-> $past(req))
        else $error("ack without request");
    chk_pulse_excl: assert property (!(o_pulse_pos && o_pulse_neg))
        else $error("both pulse outputs high");
    chk_pulse_busy: assert property ((o_pulse_pos || o_pulse_neg) |-> o_busy)
        else $error("pulse while idle");
    chk_dir_match: assert property ((o_pulse_pos || o_pulse_neg) |-> o_pulse_neg == dir_q)
        else $error("pulse on wrong direction");
    chk_busy_start: assert property (!o_busy && !start && !$past(start) |=> !o_busy)
        else $error("busy without start");
    chk_start_busy: assert property (start |-> ##[1:3] o_busy)
        else $error("start did not set busy");
    chk_sudden_stop: assert property (cmd && i_wb_dat[7:0] == apd_pkg::CMD_SUD_STOP |-> ##[1:3] !o_busy)
        else $error("sudden stop too slow");
endmodule : apd_axis_chk

bind apd_axis apd_axis_chk u_chk (
    .i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_ext_stop, .o_pulse_pos, .o_pulse_neg, .o_busy
);

// file: verif/apd_motor_model.sv
`timescale 1ns/1ps
module apd_motor_model (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    // Steps and sensor position
    input  wire logic               i_pulse_pos,
    input  wire logic               i_pulse_neg,
    input  wire logic signed [31:0] i_home_at,
    // Sensors and position
    output logic [3:0]              o_sens,
    output logic signed [31:0]      o_position
);
    // ****************************************
    // Step counting and sensors
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_position <= 32'sh0;
        end else if (i_pulse_pos) begin
            o_position <= o_position + 32'sh1;
        end else if (i_pulse_neg) begin
            o_position <= o_position - 32'sh1;
        end
    end
    assign o_sens[0] = o_position >= i_home_at - 32'sh8;
    assign o_sens[1] = o_position >= i_home_at;
    assign o_sens[2] = o_sens[1] && o_position[1:0] == 2'h0;
    assign o_sens[3] = 1'b0;
endmodule : apd_motor_model

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic               i_clk = 1'b0;
    logic               i_rst = 1'b1;
    logic               i_wb_cyc = 1'b0;
    logic               i_wb_stb = 1'b0;
    logic               i_wb_we = 1'b0;
    logic [7:0]         i_wb_adr = 8'h00;
    logic [3:0]         i_wb_sel = 4'h0;
    logic [31:0]        i_wb_dat = 32'h0;
    logic [31:0]        o_wb_dat, rd, sp, n, seed = 32'h7AA413DA;
    logic               o_wb_ack, o_pulse_pos, o_pulse_neg, o_busy;
    logic [3:0]         i_ext_stop;
    logic signed [31:0] pos, p0, p1, d, home_at = 32'sh7FFF_0000;
    int                 num_errors = 0, n_compared = 0, cycles = 0;
    apd_axis uut (.i_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
                  .o_wb_dat, .o_wb_ack, .i_ext_stop, .o_pulse_pos, .o_pulse_neg, .o_busy);
    apd_motor_model drv (.i_clk, .i_rst, .i_pulse_pos(o_pulse_pos), .i_pulse_neg(o_pulse_neg),
                         .i_home_at(home_at), .o_sens(i_ext_stop), .o_position(pos));
    // ****************************************
    // Clock, timeout and helpers
    // ****************************************
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors = num_errors + 1;
            results();
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic signed [31:0] steps(input logic [31:0] s, input logic [31:0] c);
        return $signed((s * c) >> 20);
    endfunction : steps
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= w;
        i_wb_adr <= a;
        i_wb_sel <= 4'hF;
        i_wb_dat <= v;
        do begin
            @(posedge i_clk);
        end while (o_wb_ack !== 1'b1);
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_clk);
    endtask : wb
    task automatic run(input logic [7:0] c);
        wb(1'b1, apd_pkg::ADR_CMD, {24'h0, c});
        repeat (3) @(posedge i_clk);
    endtask : run
    task automatic idle();
        while (o_busy !== 1'b0) @(posedge i_clk);
    endtask : idle
    task automatic setup(input logic [31:0] s0, input logic [31:0] s1, input logic [31:0] r, input logic [31:0] c);
        wb(1'b1, apd_pkg::ADR_INITSPD, s0);
        wb(1'b1, apd_pkg::ADR_DRVSPD, s1);
        wb(1'b1, apd_pkg::ADR_RATE, r);
        wb(1'b1, apd_pkg::ADR_PULSES, c);
    endtask : setup
    task automatic results();
        $display("Errors %0d of %0d compared", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        wb(1'b0, 8'hFC, 32'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'b0, apd_pkg::ADR_OFFSET, 32'h0);
        chk("offset", rd, apd_pkg::OFFSET_RST);
        for (int k = 0; k < 4; k++) begin
            sp = (xs() & 32'h0007_FFFF) | 32'h0001_0000;
            n  = (k == 3) ? 32'h1 : (xs() & 32'h3F) + 32'h8;
            setup(sp, sp, 32'h0, n);
            p0 = pos;
            run(k[0] ? apd_pkg::CMD_FIX_NEG : apd_pkg::CMD_FIX_POS);
            idle();
            chk("fixed steps", k[0] ? p0 - pos : pos - p0, n);
            wb(1'b0, apd_pkg::ADR_OUTCNT, 32'h0);
            chk("out count", rd, n);
        end
        $display("test fixed done");
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, apd_pkg::ADR_ACCEL, {31'h0, k == 2});
            wb(1'b1, apd_pkg::ADR_OFFSET, k == 1 ? 32'hFFFF_FFFC : apd_pkg::OFFSET_RST);
            wb(1'b1, apd_pkg::ADR_DECPT, 32'h96);
            run(apd_pkg::CMD_DECPT);
            setup(32'h8000, 32'h8_0000, 32'h40, 32'hC8);
            p0 = pos;
            run(apd_pkg::CMD_FIX_POS);
            idle();
            chk("ramp steps", pos - p0, 32'hC8);
        end
        wb(1'b1, apd_pkg::ADR_ACCEL, 32'h0);
        setup(32'h8000, 32'h8_0000, 32'h40, 32'h7D0);
        p0 = pos;
        run(apd_pkg::CMD_FIX_POS);
        repeat (600) @(posedge i_clk);
        run(apd_pkg::CMD_DEC_STOP);
        idle();
        chk("fixed ramp stop", {31'h0, pos - p0 < 32'sh7D0}, 32'h1);
        $display("test ramp done");
        setup(32'h4_0000, 32'h4_0000, 32'h0, 32'h64);
        p0 = pos;
        run(apd_pkg::CMD_FIX_POS);
        repeat (100) @(posedge i_clk);
        wb(1'b1, apd_pkg::ADR_PULSES, 32'h96);
        idle();
        chk("extended", pos - p0, 32'h96);
        run(apd_pkg::CMD_FIX_POS);
        repeat (200) @(posedge i_clk);
        wb(1'b1, apd_pkg::ADR_PULSES, 32'hA);
        p1 = pos;
        repeat (2) @(posedge i_clk);
        chk("cut busy", {31'h0, o_busy}, 32'h0);
        chk("cut steps", pos - p1, 32'h0);
        $display("test count change done");
        setup(32'h8_0000, 32'h2_0000, 32'h0, 32'h0);
        run(apd_pkg::CMD_CON_POS);
        for (int k = 0; k < 2; k++) begin
            sp = (xs() & 32'h0007_FFFF) | 32'h0001_0000;
            wb(1'b1, apd_pkg::ADR_DRVSPD, sp);
            repeat (16) @(posedge i_clk);
            p1 = pos;
            repeat (512) @(posedge i_clk);
            d = pos - p1 - steps(sp, 32'h200);
            chk("cont rate", {31'h0, d >= -1 && d <= 1}, 32'h1);
        end
        wb(1'b1, apd_pkg::ADR_CMD, {24'h0, apd_pkg::CMD_SUD_STOP});
        repeat (2) @(posedge i_clk);
        chk("sudden stop", {31'h0, o_busy}, 32'h0);
        setup(32'h8000, 32'h8_0000, 32'h100, 32'h0);
        run(apd_pkg::CMD_CON_NEG);
        repeat (3000) @(posedge i_clk);
        run(apd_pkg::CMD_DEC_STOP);
        chk("ramp down", {31'h0, o_busy}, 32'h1);
        idle();
        $display("test continuous done");
        wb(1'b1, apd_pkg::ADR_INMODE, 32'h220);
        setup(32'h4_0000, 32'h4_0000, 32'h0, 32'h0);
        home_at <= pos + 32'sh28;
        run(apd_pkg::CMD_CON_POS);
        idle();
        chk("home stop", {31'h0, pos >= home_at && pos <= home_at + 4}, 32'h1);
        home_at <= pos + 32'sh12C;
        wb(1'b1, apd_pkg::ADR_INMODE, 32'h770);
        setup(32'h8000, 32'h8_0000, 32'h100, 32'h0);
        run(apd_pkg::CMD_CON_POS);
        idle();
        chk("slowed stop", {31'h0, pos >= home_at - 8}, 32'h1);
        wb(1'b1, apd_pkg::ADR_INMODE, 32'h0);
        run(apd_pkg::CMD_CON_POS);
        repeat (100) @(posedge i_clk);
        chk("masked pins", {31'h0, o_busy}, 32'h1);
        run(apd_pkg::CMD_SUD_STOP);
        $display("test stop inputs done");
        results();
    end
endmodule : testbench
